// *** tcep_pkg.sv ***
// tcep_pkg: register map, field positions and reset values for the channel
// enable/polarity block; assumes a 32-bit Avalon-MM slave with byte addresses.
package tcep_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CHAN_CTL = 8'h20;
    localparam logic [7:0] OFF_COUNTER  = 8'h24;
    localparam logic [7:0] OFF_MODE_CTL = 8'h28;
    localparam logic [7:0] OFF_PROTECTION_LEVEL_CTL = 8'h2C;
    localparam int NUM_CHAN  = 4;
    localparam int CHAN_STEP = 4;
    localparam int POS_EN    = 0;
    localparam int POS_POL   = 1;
    localparam int POS_CEN   = 2;
    localparam int POS_CPOL  = 3;
    localparam int CTL_W     = 14;
    localparam int CNT_W     = 16;
    localparam int MODE_W    = 2;
    localparam int PROTECTION_LEVEL_W    = 2;
    localparam logic [13:0] CTL_MASK     = 14'h3FFF;
    localparam logic [13:0] CTL_POL_MASK = 14'h2AAA;
    localparam logic [13:0] CTL_RESET    = 14'h0000;
    localparam logic [15:0] CNT_RESET    = 16'h0000;
    localparam logic [1:0]  MODE_OUTPUT  = 2'h0;
    localparam logic [7:0]  MODE_RESET   = 8'h00;
    localparam logic [1:0]  PROTECTION_LEVEL_RESET   = 2'h0;
    localparam logic [1:0]  PROTECTION_LEVEL_LOCK_HI = 2'h3;
    localparam logic [1:0]  PROTECTION_LEVEL_LOCK_LO = 2'h2;
    localparam logic [3:0]  BE_LOW_HALF  = 4'h3;
    localparam logic [3:0]  BE_HIGH_HALF = 4'hC;
    localparam logic [3:0]  BE_WORD      = 4'hF;
    localparam logic [31:0] UNMAPPED_RD  = 32'h0000_0000;
endpackage

// *** tcep_channels.sv ***
// tcep_channels: four-channel enable/polarity control plus 16-bit counter.
// assumes avalon-mm master on clk, channel inputs already filtered, with the
// pins arriving asynchronously, so they are double-flopped here.
`timescale 1ns/1ps

// How it works
// - in output mode the complementary output is active high when its polarity bit is 0 and active low when 1.
// - in input mode the complementary polarity bit joins the main polarity bit to set input polarity.
// - writes to any polarity bit are dropped while the protection level is 11 or 10.
// - in output mode the complementary output is driven only while its complementary enable is 1.
// - in output mode the main output is active high with polarity 0 and active low with polarity 1.
// - in input mode with polarity 0 the rising edge is active and the input passes uninverted.
// - in input mode with polarity 1 the input is inverted and its falling edge is active.
// - in output mode the main output is driven active only while the channel enable bit is 1.
// - in input mode capture events occur only while the channel enable bit is set.
// - channels 0 to 2 use four-bit groups from bit 0, channel 3 has enable at 12 and polarity at 13.
// - the counter register reads the current count and a write loads a new count.
// - the control register accepts 16-bit and 32-bit accesses.
// - mode value 00 selects output mode and any other value selects input mode.
// - a channel mode field is writable only while that channel is disabled.
module tcep_channels
(
    input  wire logic                     clk,
    input  wire logic                     nrst,
    input  wire logic [7:0]               address,
    input  wire logic                     read,
    input  wire logic                     write,
    input  wire logic [3:0]               byteenable,
    input  wire logic [31:0]              writedata,
    output logic      [31:0]              readdata,
    output logic                          waitrequest,
    output logic                          response,
    input  wire logic                     countEnable,
    input  wire logic [3:0]               prepOutput,
    input  wire logic [3:0]               filteredChanInput,
    output logic      [3:0]               chanMainOutput,
    output logic      [3:0]               chanMainOutputEn,
    output logic      [2:0]               chanCompOutput,
    output logic      [2:0]               chanCompOutputEn,
    output logic      [3:0]               chanInputPolarized,
    output logic      [3:0]               captureEvent,
    output logic      [3:0]               chanBothEdges
);
    localparam int N = tcep_pkg::NUM_CHAN;

    logic [13:0] chanCtl_reg;
    logic [15:0] counter_reg;
    logic [7:0]  modeCtl_reg;
    logic [1:0]  protLevel_reg;
    logic        accessDone_reg;
    logic [31:0] readData_reg;
    logic        response_reg;
    logic [3:0]  inMeta_reg;
    logic [3:0]  inSync_reg;
    logic [3:0]  inPrev_reg;
    logic [3:0]  outMain_reg;
    logic [3:0]  outMainEn_reg;
    logic [2:0]  outComp_reg;
    logic [2:0]  outCompEn_reg;
    logic [3:0]  capture_reg;
    logic [3:0]  polarized_reg;
    logic [3:0]  bothEdges_reg;

    logic        isCtl;
    logic        isCnt;
    logic        isMode;
    logic        isProt;
    logic        mapped;
    logic        ctlWriteOk;
    logic        cntWriteOk;
    logic        polLocked;
    logic [13:0] ctlLaneMask;
    logic [13:0] ctlWrMask;
    logic [13:0] ctl_next;
    logic [7:0]  mode_next;
    logic [3:0]  chanEn;
    logic [3:0]  chanPol;
    logic [3:0]  compEn;
    logic [3:0]  compPol;
    logic [3:0]  isOutput;

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks: package sizes must fit the fixed port and register widths

    if (N != $bits(chanMainOutput) || N - 1 != $bits(chanCompOutput))
    begin : gen_chan_check
        $error("channel count does not fit the port widths");
    end
    if (tcep_pkg::CTL_W != $bits(chanCtl_reg) || tcep_pkg::CNT_W != $bits(counter_reg))
    begin : gen_width_check
        $error("register widths do not fit the package");
    end

    ////////////////////////////////////////////////////////////////////////////
    // address decode and access size checks

    assign isCtl  = (address == tcep_pkg::OFF_CHAN_CTL);
    assign isCnt  = (address == tcep_pkg::OFF_COUNTER);
    assign isMode = (address == tcep_pkg::OFF_MODE_CTL);
    assign isProt = (address == tcep_pkg::OFF_PROTECTION_LEVEL_CTL);
    assign mapped = isCtl | isCnt | isMode | isProt;

    // half-word or word lanes accepted on the control register
    assign ctlWriteOk = isCtl && (byteenable == tcep_pkg::BE_WORD
                               || byteenable == tcep_pkg::BE_LOW_HALF
                               || byteenable == tcep_pkg::BE_HIGH_HALF);
    // counter only takes whole words
    assign cntWriteOk = isCnt && (byteenable == tcep_pkg::BE_WORD);

    assign polLocked = (protLevel_reg == tcep_pkg::PROTECTION_LEVEL_LOCK_HI)
                    || (protLevel_reg == tcep_pkg::PROTECTION_LEVEL_LOCK_LO);

    ////////////////////////////////////////////////////////////////////////////
    // field extraction per channel

    always_comb
    begin
        for (int c = 0; c < N; c++)
        begin
            // four-bit groups, channel 3 only has the low two bits
            chanEn[c]  = chanCtl_reg[c * tcep_pkg::CHAN_STEP + tcep_pkg::POS_EN];
            chanPol[c] = chanCtl_reg[c * tcep_pkg::CHAN_STEP + tcep_pkg::POS_POL];
            compEn[c]  = (c < N - 1) ?
                chanCtl_reg[c * tcep_pkg::CHAN_STEP + tcep_pkg::POS_CEN] : 1'b0;
            compPol[c] = (c < N - 1) ?
                chanCtl_reg[c * tcep_pkg::CHAN_STEP + tcep_pkg::POS_CPOL] : 1'b0;
            isOutput[c] = (modeCtl_reg[c * tcep_pkg::MODE_W +: tcep_pkg::MODE_W]
                           == tcep_pkg::MODE_OUTPUT);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control register write merge

    always_comb
    begin
        ctlLaneMask = '0;
        if (byteenable[0])
            ctlLaneMask[7:0] = 8'hFF;
        if (byteenable[1])
            ctlLaneMask[13:8] = 6'h3F;
        ctlWrMask = ctlLaneMask & tcep_pkg::CTL_MASK;
        if (polLocked)
            ctlWrMask = ctlWrMask & ~tcep_pkg::CTL_POL_MASK;
        ctl_next = (chanCtl_reg & ~ctlWrMask) | (writedata[13:0] & ctlWrMask);
    end

    always_comb
    begin
        mode_next = modeCtl_reg;
        for (int c = 0; c < N; c++)
        begin
            if (!chanEn[c] && byteenable[0])
                mode_next[c * tcep_pkg::MODE_W +: tcep_pkg::MODE_W] =
                    writedata[c * tcep_pkg::MODE_W +: tcep_pkg::MODE_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus handshake: one wait cycle, answer on the second edge

    assign waitrequest = (read | write) & ~accessDone_reg;
    assign readdata    = readData_reg;
    assign response    = response_reg;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            accessDone_reg <= 1'b0;
        else
            accessDone_reg <= (read | write) & ~accessDone_reg;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            response_reg <= 1'b0;
        else if ((read | write) && !accessDone_reg)
            response_reg <= ~mapped | (isCnt & ~cntWriteOk) | (isCtl & ~ctlWriteOk);
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            readData_reg <= tcep_pkg::UNMAPPED_RD;
        end
        else if ((read | write) && !accessDone_reg)
        begin
            readData_reg <= tcep_pkg::UNMAPPED_RD;
            if (read && isCtl)
                readData_reg <= {18'h00000, chanCtl_reg};
            else if (read && isCnt)
                readData_reg <= {16'h0000, counter_reg};
            else if (read && isMode)
                readData_reg <= {24'h000000, modeCtl_reg};
            else if (read && isProt)
                readData_reg <= {30'h00000000, protLevel_reg};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers; writes commit on the edge where waitrequest is low

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            chanCtl_reg <= tcep_pkg::CTL_RESET;
        else if (write && accessDone_reg && ctlWriteOk)
            chanCtl_reg <= ctl_next;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            counter_reg <= tcep_pkg::CNT_RESET;
        else if (write && accessDone_reg && cntWriteOk)
            counter_reg <= writedata[15:0];
        else if (countEnable)
            counter_reg <= counter_reg + 16'h0001;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            modeCtl_reg <= tcep_pkg::MODE_RESET;
        else if (write && accessDone_reg && isMode)
            modeCtl_reg <= mode_next;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            protLevel_reg <= tcep_pkg::PROTECTION_LEVEL_RESET;
        else if (write && accessDone_reg && isProt && byteenable[0])
            protLevel_reg <= writedata[1:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // output stage

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            outMain_reg   <= 4'h0;
            outMainEn_reg <= 4'h0;
        end
        else
        begin
            for (int c = 0; c < N; c++)
            begin
                outMainEn_reg[c] <= isOutput[c] & chanEn[c];
                outMain_reg[c]   <= isOutput[c] & chanEn[c]
                                  & (prepOutput[c] ^ chanPol[c]);
            end
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            outComp_reg   <= 3'h0;
            outCompEn_reg <= 3'h0;
        end
        else
        begin
            for (int c = 0; c < N - 1; c++)
            begin
                outCompEn_reg[c] <= isOutput[c] & compEn[c];
                outComp_reg[c]   <= isOutput[c] & compEn[c]
                                  & (~prepOutput[c] ^ compPol[c]);
            end
        end
    end

    assign chanMainOutput   = outMain_reg;
    assign chanMainOutputEn = outMainEn_reg;
    assign chanCompOutput   = outComp_reg;
    assign chanCompOutputEn = outCompEn_reg;

    ////////////////////////////////////////////////////////////////////////////
    // input stage: synchronise, polarise, detect active edge

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            inMeta_reg <= 4'h0;
            inSync_reg <= 4'h0;
        end
        else
        begin
            inMeta_reg <= filteredChanInput;
            inSync_reg <= inMeta_reg;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            inPrev_reg    <= 4'h0;
            polarized_reg <= 4'h0;
            capture_reg   <= 4'h0;
        end
        else
        begin
            inPrev_reg <= inSync_reg;
            for (int c = 0; c < N; c++)
            begin
                // polarity 0 passes through, 1 inverts
                polarized_reg[c] <= inSync_reg[c] ^ chanPol[c];
                // both polarity bits set selects both edges
                if (chanPol[c] && compPol[c])
                    capture_reg[c] <= ~isOutput[c] & chanEn[c]
                                    & (inSync_reg[c] ^ inPrev_reg[c]);
                else if (chanPol[c])
                    capture_reg[c] <= ~isOutput[c] & chanEn[c]
                                    & ~inSync_reg[c] & inPrev_reg[c];
                else
                    capture_reg[c] <= ~isOutput[c] & chanEn[c]
                                    & inSync_reg[c] & ~inPrev_reg[c];
            end
        end
    end

    assign chanInputPolarized = polarized_reg;
    assign captureEvent       = capture_reg;
    // both-edge capture flag, registered like the other data outputs
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            bothEdges_reg <= 4'h0;
        else
            bothEdges_reg <= chanPol & compPol & ~isOutput;
    end

    assign chanBothEdges      = bothEdges_reg;
endmodule

// *** tcep_channels_checker.sv ***
// tcep_channels_checker: port assertions for tcep_channels.
// assumes one clock domain, bound onto the design top.
`timescale 1ns/1ps
module tcep_channels_checker
(
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [7:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        response,
    input wire logic [3:0]  chanMainOutput,
    input wire logic [3:0]  chanMainOutputEn,
    input wire logic [3:0]  captureEvent
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic req;
    logic done;
    assign req = read | write;
    assign done = req & ~waitrequest;
    chk_wait_one: assert property (req && waitrequest |=> !waitrequest)
        else $error("request still waiting in second cycle");
    chk_read_hold: assert property (!req && !$past(req) |-> $stable(readdata))
        else $error("read data moved while idle");
    chk_unmapped_zero: assert property (done && read && !(address inside {8'h20, 8'h24,
        8'h28, 8'h2C}) |-> response && readdata == 32'h0)
        else $error("unmapped read not zero with error");
    chk_ctl_size: assert property (done && write && address == 8'h20 &&
        !(byteenable inside {4'hF, 4'h3, 4'hC}) |-> response)
        else $error("odd control access not refused");
    chk_cnt_word: assert property (done && write && address == 8'h24 |->
        response == (byteenable != 4'hF))
        else $error("counter access size answer wrong");
    chk_off_low: assert property ((chanMainOutput & ~chanMainOutputEn) == 4'h0)
        else $error("undriven main output not low");
    chk_cap_input: assert property ((captureEvent & chanMainOutputEn) == 4'h0)
        else $error("capture on output channel");
    chk_reset_clear: assert property ($rose(nrst) |-> chanMainOutputEn == 4'h0 &&
        captureEvent == 4'h0 ##1 chanMainOutputEn == 4'h0)
        else $error("outputs not clear after reset");
    cover property (done && write);
    cover property (captureEvent != 4'h0);
    cover property (done && response);
endmodule
bind tcep_channels tcep_channels_checker tcep_channels_checker_inst
(
    .clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .response(response), .chanMainOutput(chanMainOutput),
    .chanMainOutputEn(chanMainOutputEn), .captureEvent(captureEvent)
);

// *** tcep_pin_model.sv ***
// tcep_pin_model: the channel input pins outside the timer.
// assumes the bench sets the wanted pin level per channel.
`timescale 1ns/1ps
module tcep_pin_model
(
    input  wire logic       clk,
    input  wire logic [3:0] pinLevel,
    output logic      [3:0] filteredChanInput
);
    // pins move clear of the timer edge, as an async source would
    initial filteredChanInput = 4'h0;
    always @(negedge clk) filteredChanInput <= pinLevel;
endmodule

// *** tb.sv ***
// tb: self-checking bench for tcep_channels.
// assumes tcep_pin_model drives the channel pins.
`timescale 1ns/1ps
module tb;
    logic        clk = 1'b0, nrst = 1'b0, read = 1'b0, write = 1'b0, cntEn = 1'b0;
    logic [7:0]  address = 8'h00;
    logic [3:0]  be = 4'h0, prep = 4'h0, pinLevel = 4'h0, filtIn, mainOut, mainEn;
    logic [3:0]  polIn, capEv, both;
    logic [2:0]  compOut, compEn;
    logic [31:0] wdata = 32'h0, readdata, rd;
    logic        waitrequest, response, rsp;
    int          miscompares = 0, tests_run = 0, cycles = 0, caps;
    tcep_channels tcep_channels_inst
    (
        .clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
        .byteenable(be), .writedata(wdata), .readdata(readdata),
        .waitrequest(waitrequest), .response(response), .countEnable(cntEn),
        .prepOutput(prep), .filteredChanInput(filtIn), .chanMainOutput(mainOut),
        .chanMainOutputEn(mainEn), .chanCompOutput(compOut), .chanCompOutputEn(compEn),
        .chanInputPolarized(polIn), .captureEvent(capEv), .chanBothEdges(both)
    );
    tcep_pin_model tcep_pin_model_inst
    (
        .clk(clk), .pinLevel(pinLevel), .filteredChanInput(filtIn)
    );
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            miscompares = miscompares + 1;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp)
        begin
            miscompares = miscompares + 1;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // request raised after a rising edge, held until waitrequest is seen low at one
    task automatic bus(input logic wr, input logic [7:0] a, input logic [3:0] b,
                       input logic [31:0] d);
        @(posedge clk);
        read <= ~wr;
        write <= wr;
        address <= a;
        be <= b;
        wdata <= d;
        do @(posedge clk); while (waitrequest !== 1'b0);
        rd = readdata;
        rsp = response;
        read <= 1'b0;
        write <= 1'b0;
        // registered outputs follow one edge after the commit
        @(posedge clk);
        @(negedge clk);
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 4'hF, 32'h0);
        check(what, rd, exp);
    endtask
    task automatic pin(input logic lvl, input int exp);
        @(posedge clk);
        pinLevel <= {3'h0, lvl};
        caps = 0;
        repeat (8) @(negedge clk) caps = caps + (capEv[0] === 1'b1);
        check("capture count", caps, exp);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        rdchk("ctl", 8'h20, 32'h0);
        rdchk("cnt", 8'h24, 32'h0);
        $display("test reset done");
    endtask
    task automatic test_outputs();
        @(posedge clk);
        prep <= 4'hF;
        bus(1'b1, 8'h20, 4'hF, 32'hFFFF_FFFF);
        rdchk("ctl map", 8'h20, 32'h3FFF);
        check("mainEn", mainEn, 4'hF);
        check("mainOut", mainOut, 4'h0);
        check("compEn", compEn, 3'h7);
        check("compOut", compOut, 3'h7);
        @(posedge clk);
        prep <= 4'hA;
        bus(1'b1, 8'h20, 4'h3, 32'h1115);
        check("mainOut", mainOut, 4'hA);
        check("compEn", compEn, 3'h1);
        check("compOut", compOut[0], 1'b1);
        bus(1'b1, 8'h20, 4'hF, 32'h0);
        check("mainEn", mainEn, 4'h0);
        $display("test outputs done");
    endtask
    task automatic test_protect();
        for (int p = 2; p < 4; p++)
        begin
            bus(1'b1, 8'h2C, 4'hF, p);
            bus(1'b1, 8'h20, 4'hF, 32'h3FFF);
            rdchk("locked pol", 8'h20, 32'h1555);
            bus(1'b1, 8'h20, 4'hF, 32'h0);
        end
        bus(1'b1, 8'h2C, 4'hF, 32'h1);
        bus(1'b1, 8'h20, 4'hF, 32'h2AAA);
        rdchk("open pol", 8'h20, 32'h2AAA);
        bus(1'b1, 8'h2C, 4'hF, 32'h0);
        bus(1'b1, 8'h20, 4'hF, 32'h0);
        $display("test protect done");
    endtask
    task automatic test_sizes();
        bus(1'b1, 8'h20, 4'hC, 32'hFFFF_FFFF);
        check("high half rsp", rsp, 1'b0);
        rdchk("reserved", 8'h20, 32'h0);
        bus(1'b1, 8'h20, 4'h3, 32'h1);
        rdchk("half word", 8'h20, 32'h1);
        bus(1'b1, 8'h20, 4'h1, 32'h0);
        check("byte rsp", rsp, 1'b1);
        bus(1'b1, 8'h24, 4'h3, 32'h55);
        check("cnt half rsp", rsp, 1'b1);
        rdchk("unmapped", 8'h40, 32'h0);
        check("unmapped rsp", rsp, 1'b1);
        rdchk("byte refused", 8'h20, 32'h1);
        bus(1'b1, 8'h20, 4'hF, 32'h0);
        $display("test sizes done");
    endtask
    task automatic test_counter();
        bus(1'b1, 8'h24, 4'hF, 32'hFFFE);
        rdchk("cnt load", 8'h24, 32'hFFFE);
        @(posedge clk);
        cntEn <= 1'b1;
        repeat (3) @(posedge clk);
        cntEn <= 1'b0;
        rdchk("cnt wrap", 8'h24, 32'h1);
        $display("test counter done");
    endtask
    task automatic test_midreset();
        bus(1'b1, 8'h20, 4'hF, 32'h5);
        bus(1'b1, 8'h24, 4'hF, 32'h1234);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        check("mainEn in reset", mainEn, 4'h0);
        nrst <= 1'b1;
        rdchk("ctl after reset", 8'h20, 32'h0);
        rdchk("cnt after reset", 8'h24, 32'h0);
        $display("test midreset done");
    endtask
    task automatic test_input();
        bus(1'b1, 8'h28, 4'hF, 32'h1);
        bus(1'b1, 8'h20, 4'hF, 32'h1);
        bus(1'b1, 8'h28, 4'hF, 32'h0);
        rdchk("mode locked", 8'h28, 32'h1);
        check("input not driven", mainEn[0], 1'b0);
        pin(1'b1, 1);
        check("polarized", polIn[0], 1'b1);
        pin(1'b0, 0);
        bus(1'b1, 8'h20, 4'hF, 32'h3);
        pin(1'b1, 0);
        check("inverted", polIn[0], 1'b0);
        pin(1'b0, 1);
        bus(1'b1, 8'h20, 4'hF, 32'h2);
        pin(1'b1, 0);
        pin(1'b0, 0);
        bus(1'b1, 8'h20, 4'hF, 32'hB);
        check("both edges", both[0], 1'b1);
        pin(1'b1, 1);
        pin(1'b0, 1);
        bus(1'b1, 8'h20, 4'hF, 32'h0);
        $display("test input done");
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        test_reset();
        test_outputs();
        test_protect();
        test_sizes();
        test_counter();
        test_midreset();
        test_input();
        report_and_stop();
    end
endmodule
